// *** hdl/jie_exec.sv ***
// Purpose: decode and execute absolute jump and file register increment
// Assumes: prog_word shows the word at prog_addr; file_rd_data answers file_addr same cycle
// Notes: phase Q1..Q4 each one clock; file write strobe stands during Q4
//
// Summary of operation
// - Jump loads the 20-bit literal into counter bits 20:1, bit 0 stays zero.
// - Jump reaches every word of the full 2-Mbyte program space.
// - Jump takes two cycles; the second is a no-op refilling the fetch.
// - Jump first word is 1110 1111 plus k7:0; second word 1111 plus k19:8.
// - Increment reads the addressed file register and adds one.
// - Destination bit 0 writes the accumulator, 1 writes back to the file register.
// - Access bit 0 uses the access bank; 1 uses the bank select register.
// - Bank select register sets the increment bank when the access bit is one.
// - Increment updates carry, digit carry, negative, overflow and zero flags.
// - Increment decodes from top bits 001010, then d, a and 8-bit address.
`default_nettype none
module jie_exec
  import jie_pkg::*;
#(
  parameter logic [7:0] ACCESS_SPLIT = ACCESS_SPLIT_DEF
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] prog_word,
  input wire logic [3:0] bank_sel_value,
  input wire logic [7:0] file_rd_data,
  output logic [PC_W-1:0] prog_addr,
  output jie_file_bus_t file_bus,
  output logic [7:0] wreg_value,
  output jie_flags_t status_flags
);
  jie_phase_t phase_reg, phase_next;
  jie_op_t op_reg, op_next;
  logic [15:0] ir_reg, ir_next;
  logic flush_reg, flush_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic [7:0] rd_reg, rd_next;
  logic [7:0] wreg_reg, wreg_next;
  jie_flags_t status_reg, status_next;
  jie_file_bus_t file_reg, file_next;
  logic [7:0] alu_result;
  jie_flags_t alu_flags;
  logic jump_take;
  logic [TGT_W-1:0] jump_target;

  // Opcode classification of a first word
  function automatic jie_op_t decode_op(input logic [15:0] w);
    if (w[15:8] == JUMP_OPC)
      return OP_JUMP;
    else if (w[15:10] == INCR_OPC)
      return OP_INCR;
    else
      return OP_NOP;
  endfunction

  // Operand bank: access bank splits low and high halves
  function automatic logic [11:0] file_address(input logic [15:0] w, input logic [3:0] bank_sel);
    if (w[ACC_BIT])
      return {bank_sel, w[7:0]};
    else if (w[7:0] < ACCESS_SPLIT)
      return {BANK_LOW, w[7:0]};
    else
      return {BANK_HIGH, w[7:0]};
  endfunction

  jie_incr_alu u_alu (
    .operand(rd_reg),
    .result(alu_result),
    .flags(alu_flags)
  );

  // Second word must carry the marker nibble, else the jump degrades to a no-op
  assign jump_take = (phase_reg == PH_Q4) && (op_reg == OP_JUMP) &&
                     (prog_word[15:12] == JUMP2_NIB);
  assign jump_target = {prog_word[11:0], ir_reg[7:0]};

  // Next state of the instruction cycle
  always_comb
  begin
    phase_next = phase_reg;
    op_next = op_reg;
    ir_next = ir_reg;
    flush_next = flush_reg;
    pc_next = pc_reg;
    rd_next = rd_reg;
    wreg_next = wreg_reg;
    status_next = status_reg;
    file_next = file_reg;
    file_next.wr_en = 1'b0;
    unique case (phase_reg)
      PH_Q1:
      begin
        phase_next = PH_Q2;
        if (flush_reg)
        begin
          // Refill cycle: word at new target is fetched next cycle
          op_next = OP_NOP;
        end
        else
        begin
          ir_next = prog_word;
          op_next = decode_op(prog_word);
          pc_next = pc_reg + PC_STEP;
          file_next.addr = file_address(prog_word, bank_sel_value);
        end
      end
      PH_Q2:
      begin
        phase_next = PH_Q3;
        if (op_reg == OP_INCR)
          rd_next = file_rd_data;
      end
      PH_Q3:
      begin
        phase_next = PH_Q4;
        if (op_reg == OP_INCR)
        begin
          status_next = alu_flags;
          if (ir_reg[DEST_BIT])
          begin
            file_next.wr_en = 1'b1;
            file_next.wr_data = alu_result;
          end
          else
            wreg_next = alu_result;
        end
      end
      PH_Q4:
      begin
        phase_next = PH_Q1;
        flush_next = 1'b0;
        if (jump_take)
        begin
          // Full 20-bit word target, no paging
          pc_next = {jump_target, 1'b0};
          flush_next = 1'b1;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg <= PH_Q1;
      op_reg <= OP_NOP;
      ir_reg <= 16'h0000;
      flush_reg <= 1'b0;
      pc_reg <= PC_RESET;
      rd_reg <= BYTE_ZERO;
      wreg_reg <= BYTE_ZERO;
      status_reg <= FLAGS_RESET;
      file_reg <= FILE_BUS_RESET;
    end
    else
    begin
      phase_reg <= phase_next;
      op_reg <= op_next;
      ir_reg <= ir_next;
      flush_reg <= flush_next;
      pc_reg <= pc_next;
      rd_reg <= rd_next;
      wreg_reg <= wreg_next;
      status_reg <= status_next;
      file_reg <= file_next;
    end
  end

  // Outputs straight from registers
  assign prog_addr = pc_reg;
  assign file_bus = file_reg;
  assign wreg_value = wreg_reg;
  assign status_flags = status_reg;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_JUMP_TARGET: assert property (
    jump_take |=> pc_reg == {$past(jump_target), 1'b0})
    else $error("jump target not loaded into counter");
  AST_PC_EVEN: assert property (
    pc_reg[0] == 1'b0)
    else $error("program counter not word aligned");
  AST_JUMP_FLUSH: assert property (
    jump_take |=> flush_reg [*4] ##1 !flush_reg)
    else $error("jump refill cycle wrong length");
  AST_FLUSH_NOP: assert property (
    (flush_reg && phase_reg == PH_Q1) |=> op_reg == OP_NOP && $stable(pc_reg))
    else $error("refill cycle executed something");
  AST_JUMP_DECODE: assert property (
    (phase_reg == PH_Q1 && !flush_reg && prog_word[15:8] == JUMP_OPC)
    |=> op_reg == OP_JUMP)
    else $error("jump opcode not decoded");
  AST_INCR_FILE: assert property (
    (phase_reg == PH_Q3 && op_reg == OP_INCR && ir_reg[DEST_BIT])
    |=> file_reg.wr_en && file_reg.wr_data == $past(rd_reg) + BYTE_ONE ##1 !file_reg.wr_en)
    else $error("increment not written back to file");
  AST_INCR_W: assert property (
    (phase_reg == PH_Q3 && op_reg == OP_INCR && !ir_reg[DEST_BIT])
    |=> !file_reg.wr_en && wreg_reg == $past(rd_reg) + BYTE_ONE)
    else $error("increment not written to accumulator");
  AST_BANK_SELECT: assert property (
    (phase_reg == PH_Q2 && op_reg == OP_INCR && ir_reg[ACC_BIT])
    |-> file_reg.addr[11:8] == $past(bank_sel_value))
    else $error("bank select register not used");
  AST_BANK_ACCESS: assert property (
    (phase_reg == PH_Q2 && op_reg == OP_INCR && !ir_reg[ACC_BIT])
    |-> file_reg.addr[11:8] == ((ir_reg[7:0] < ACCESS_SPLIT) ? BANK_LOW : BANK_HIGH))
    else $error("access bank not used");
  AST_ZERO_CARRY: assert property (
    (phase_reg == PH_Q3 && op_reg == OP_INCR)
    |=> status_reg.z == ($past(rd_reg) == BYTE_MAX) && status_reg.c == status_reg.z)
    else $error("zero or carry flag wrong");
  AST_JUMP_FLAGS: assert property (
    (op_reg == OP_JUMP || flush_reg) |=> $stable(status_reg))
    else $error("jump changed status flags");
  AST_INCR_DECODE: assert property (
    (phase_reg == PH_Q1 && !flush_reg && prog_word[15:10] == INCR_OPC)
    |=> op_reg == OP_INCR ##2 phase_reg == PH_Q4)
    else $error("increment not decoded");

  COV_JUMP: cover property (jump_take ##5 phase_reg == PH_Q1);
  COV_INCR_FILE: cover property (file_reg.wr_en);
  COV_INCR_W: cover property (phase_reg == PH_Q3 && op_reg == OP_INCR && !ir_reg[DEST_BIT]);
  COV_OVERFLOW: cover property (phase_reg == PH_Q3 && op_reg == OP_INCR && rd_reg == BYTE_SMAX);
endmodule // jie_exec
`default_nettype wire

// *** hdl/jie_pkg.sv ***
// Purpose: shared constants and types for the jump and increment executor
// Assumes: 16-bit program words, 8-bit data path, 21-bit byte program counter
// Notes: four clock phases form one instruction cycle
`default_nettype none
package jie_pkg;
  // Program counter and word layout
  localparam int PC_W = 21;
  localparam int TGT_W = 20;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  // Opcode fields
  localparam logic [7:0] JUMP_OPC = 8'hEF;
  localparam logic [3:0] JUMP2_NIB = 4'hF;
  localparam logic [5:0] INCR_OPC = 6'h0A;
  localparam int DEST_BIT = 9;
  localparam int ACC_BIT = 8;
  // Access bank split and bank numbers
  localparam logic [7:0] ACCESS_SPLIT_DEF = 8'h80;
  localparam logic [3:0] BANK_LOW = 4'h0;
  localparam logic [3:0] BANK_HIGH = 4'hF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [7:0] BYTE_SMAX = 8'h7F;
  localparam logic [3:0] NIB_MAX = 4'hF;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} jie_phase_t;
  typedef enum logic [1:0] {OP_NOP, OP_JUMP, OP_INCR} jie_op_t;

  typedef struct packed {
    logic n;
    logic overflow;
    logic z;
    logic digit_carry;
    logic c;
  } jie_flags_t;

  typedef struct packed {
    logic [11:0] addr;
    logic wr_en;
    logic [7:0] wr_data;
  } jie_file_bus_t;

  localparam jie_flags_t FLAGS_RESET = 5'h00;
  localparam jie_file_bus_t FILE_BUS_RESET = 21'h000000;
endpackage
`default_nettype wire

// *** hdl/jie_incr_alu.sv ***
// Purpose: eight-bit increment with arithmetic flags
// Assumes: purely combinational, operand held stable by the caller
// Notes: the five flags follow an add of one
`default_nettype none
module jie_incr_alu
  import jie_pkg::*;
(
  input wire logic [7:0] operand,
  output logic [7:0] result,
  output jie_flags_t flags
);
  logic [8:0] sum;

  // Add one and derive the flags
  always_comb
  begin
    sum = {1'b0, operand} + {1'b0, BYTE_ONE};
    result = sum[7:0];
    flags.c = sum[8];
    flags.digit_carry = (operand[3:0] == NIB_MAX);
    flags.n = sum[7];
    flags.overflow = (operand == BYTE_SMAX);
    flags.z = (sum[7:0] == BYTE_ZERO);
  end
endmodule // jie_incr_alu
`default_nettype wire

// *** sim/jump_and_increment_exec_tb.sv ***
// Purpose: self-checking bench for the jump and increment executor
// Assumes: one instruction word per four clocks, default access split
// Notes: checks sampled on the falling edge, stimulus on the rising edge
`default_nettype none
module jump_and_increment_exec_tb
  import jie_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] prog_word = 16'h0000;
  logic [3:0] bank_sel_value = 4'h0;
  logic [7:0] file_rd_data = 8'h00;
  logic [PC_W-1:0] prog_addr;
  jie_file_bus_t file_bus;
  logic [7:0] wreg_value;
  jie_flags_t status_flags;
  logic [31:0] seed = 32'h0000A1F3;
  logic [31:0] r;
  logic [PC_W-1:0] exp_pc = 21'h000000;
  logic [7:0] exp_w = 8'h00;
  jie_flags_t exp_fl = 5'h00;
  int n_fail = 0;
  int tests_run = 0;

  jie_exec i_dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .prog_word(prog_word),
    .bank_sel_value(bank_sel_value),
    .file_rd_data(file_rd_data),
    .prog_addr(prog_addr),
    .file_bus(file_bus),
    .wreg_value(wreg_value),
    .status_flags(status_flags)
  );

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // Xorshift source, fixed seed keeps runs repeatable
  function automatic logic [31:0] xrand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Flags expected after adding one
  function automatic jie_flags_t flags_of(input logic [7:0] v);
    jie_flags_t f;
    logic [7:0] s;
    s = v + 8'h01;
    f.c = (v == 8'hFF);
    f.digit_carry = (v[3:0] == 4'hF);
    f.n = s[7];
    f.overflow = (v == 8'h7F);
    f.z = (s == 8'h00);
    return f;
  endfunction

  // Single comparison point
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    tests_run++;
    if (seen !== expv)
    begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  // One increment; inputs disturbed after their sampling edge to catch late sampling
  task automatic run_incr(input logic d, input logic a, input logic [7:0] f,
                          input logic [3:0] b, input logic [7:0] v);
    logic [11:0] ea;
    logic [7:0] nv;
    ea = a ? {b, f} : ((f < ACCESS_SPLIT_DEF) ? {BANK_LOW, f} : {BANK_HIGH, f});
    nv = v + 8'h01; // Held at eight bits so 0xFF wraps to zero as in hardware
    prog_word <= {INCR_OPC, d, a, f};
    bank_sel_value <= b;
    file_rd_data <= v;
    exp_pc = exp_pc + PC_STEP;
    @(posedge sys_clk);
    bank_sel_value <= ~b;
    prog_word <= 16'h0000;
    @(negedge sys_clk);
    chk(file_bus.addr, ea);
    chk(prog_addr, exp_pc);
    chk(file_bus.wr_en, 0);
    chk(status_flags, exp_fl);
    @(posedge sys_clk);
    file_rd_data <= ~v;
    @(posedge sys_clk);
    @(negedge sys_clk);
    exp_fl = flags_of(v);
    if (!d)
      exp_w = nv;
    chk(status_flags, exp_fl);
    chk(wreg_value, exp_w);
    chk(file_bus.wr_en, d);
    if (d)
      chk(file_bus.wr_data, nv);
    chk(file_bus.addr, ea);
    @(posedge sys_clk);
  endtask

  // Two-word jump; a bad second word aborts and the next word executes
  task automatic jmp(input logic [19:0] k, input logic good);
    prog_word <= {JUMP_OPC, k[7:0]};
    exp_pc = exp_pc + PC_STEP;
    @(posedge sys_clk);
    prog_word <= {(good ? JUMP2_NIB : 4'h7), k[19:8]};
    @(negedge sys_clk);
    chk(prog_addr, exp_pc);
    repeat (3) @(posedge sys_clk);
    if (good)
    begin
      exp_pc = {k, 1'b0};
      prog_word <= {INCR_OPC, 2'b00, 8'h00}; // Would clobber wreg if refill ran it
      repeat (4)
      begin
        @(negedge sys_clk);
        chk(prog_addr, exp_pc);
        chk(status_flags, exp_fl);
        chk(wreg_value, exp_w);
        @(posedge sys_clk);
      end
    end
  endtask

  task automatic wrap_up();
    $display("Counts: tests_run %0d n_fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred clocks the tests need
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end

  // Main sequence
  initial
  begin
    repeat (11) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(prog_addr, PC_RESET);
    chk(wreg_value, 8'h00);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    run_incr(1'b1, 1'b0, 8'h7F, 4'h3, 8'hFF);
    run_incr(1'b0, 1'b0, 8'h80, 4'h3, 8'h7F);
    run_incr(1'b1, 1'b1, 8'h12, 4'h5, 8'h0F);
    run_incr(1'b0, 1'b1, 8'hFF, 4'hF, 8'h00);
    $display("test increment corners done");
    jmp(20'hFFFFF, 1'b1);
    run_incr(1'b0, 1'b0, 8'h00, 4'h1, 8'h41);
    jmp(20'h00000, 1'b1);
    jmp(20'h12345, 1'b0);
    run_incr(1'b1, 1'b1, 8'h80, 4'hA, 8'hFE);
    jmp(20'hA5A5A, 1'b1);
    jmp(20'h5A5A5, 1'b1);
    $display("test jump corners done");
    repeat (80)
    begin
      r = xrand();
      if (r[1:0] == 2'b00)
        jmp(r[31:12], r[2] | r[3]);
      else
        run_incr(r[4], r[5], r[15:8], r[19:16], r[27:20]);
    end
    $display("test random mix done");
    wrap_up();
  end
endmodule // jump_and_increment_exec_tb
`default_nettype wire
